//--- rtc_pkg.sv
// Purpose: shared constants for the rf transmit control block
// Assumes: 20 MHz system clock, Avalon-MM register access, 32-bit data
// Notes:   byte addresses, field positions, reset values and timing counts
package rtc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int CAL_TIME_NS    = 5000;   // sub-band search budget
  localparam int LOCK_TIME_NS   = 1000000; // default lock timeout
  localparam int XTAL_PRESCALE  = 52;     // fixed crystal pre-divider
  localparam logic [5:0] XTAL_PRE_LAST = 6'(XTAL_PRESCALE - 1);

  ////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [15:0] ADDR_BAUD   = 16'h1830;
  localparam logic [15:0] ADDR_CTRL   = 16'h1834;
  localparam logic [15:0] ADDR_STATUS = 16'h1838;
  localparam logic [15:0] ADDR_RSTACK = 16'h183C;
  localparam logic [15:0] ADDR_FREQA  = 16'h1840;
  localparam logic [15:0] ADDR_FREQB  = 16'h1844;

  // reset values
  localparam logic [7:0]  BAUD_RESET  = 8'h34;

  // control register fields
  localparam int CTRL_SEND      = 0;
  localparam int CTRL_MOD       = 1;
  localparam int CTRL_BAND      = 2;
  localparam int CTRL_PWR_LO    = 3;   // five bits, 3..7
  localparam int CTRL_IRQ_EN    = 8;
  localparam int CTRL_LV_EN     = 9;
  localparam int CTRL_PC_EN     = 10;
  localparam int CTRL_PER_FRAME = 11;
  localparam int CTRL_FRAMES_LO = 12;  // four bits, 12..15
  localparam int CTRL_DDATA     = 16;
  localparam int CTRL_DMODE     = 17;

  // status register fields
  localparam int STAT_READY     = 0;
  localparam int STAT_ERR       = 1;
  localparam int STAT_LV        = 2;
  localparam int STAT_DONE      = 3;
  localparam int STAT_REG_OK    = 4;
  localparam int STAT_BAND_LO   = 8;

  // reset/acknowledge register fields (write one, read zero)
  localparam int RST_BLOCK      = 0;
  localparam int RST_ACK        = 1;

  // power levels available
  localparam logic [4:0] PWR_LEVELS = 5'h15;

  typedef enum logic [2:0] {
    RTC_IDLE, RTC_REG_UP, RTC_PRECHG, RTC_CAL, RTC_LOCK, RTC_TX
  } rtc_state_t;

endpackage

//--- rtc_top.sv
// Purpose: control of the rf output stage: start, lock wait, abort, flags,
//          pre-charge sequencing, vco sub-band search and baud divider
// Assumes: analog status pins are asynchronous; buffer and frame strobes and
//          the crystal tick come from logic on clk_in
// Notes:   registers reached over Avalon-MM, one wait cycle per access
// Notes on behaviour
// - stage powered only while send set
// - ready flag shows pll locked, able to send
// - modulation bit picks ook or fsk words
// - band bit clear 315 MHz, set 434 MHz
// - five-bit power field, 21 levels
// - abort when lock not seen within timeout
// - abort on lock loss after lock
// - abort when crystal monitor falls
// - abort: rf off, send cleared, error set
// - error flag interrupts if enabled, ack clears
// - low-voltage flag, ack clears once recovered
// - supply collapse losing lock terminates transmission
// - block reset from power-on or software bit
// - block reset leaves data buffer untouched
// - interrupt when send clears after buffer
// - zero repeat: one frame; else per-frame select
// - done flag gated by enable, ack clears
// - pre-charge starts after digital regulator ready
// - precharge until 1.5 V reached, then continue
// - sub-band successive approximation each vco start
// - calibration reference: mean or second word
// - baud: crystal over 52 times divider+1
// - send auto clears; software zero stops early
`timescale 1ns/10ps
`default_nettype none

module rtc_top
  import rtc_pkg::*;
#(
  parameter int FREQ_W     = 16,
  parameter int BAND_W     = 6,
  parameter int LOCK_TO_NS = LOCK_TIME_NS
) (
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  // avalon-mm slave
  input  wire logic [15:0]       avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // analog side status pins
  input  wire logic              rf_poweron_reset_in,
  input  wire logic              pll_lock_in,
  input  wire logic              crystal_osc_ok_in,
  input  wire logic              supply_low_in,
  input  wire logic              dreg_ok_in,
  input  wire logic              cap_ok_in,
  input  wire logic              vco_above_ref_in,
  // same-clock strobes from crystal, buffer and frame logic
  input  wire logic              xtal_tick_in,
  input  wire logic              buf_data_in,
  input  wire logic              frame_end_in,
  input  wire logic              frame_last_in,
  // analog controls
  output logic                   areg_en_out,
  output logic                   precharge_on_out,
  output logic                   crystal_osc_en_out,
  output logic                   vco_en_out,
  output logic                   pll_en_out,
  output logic                   pa_en_out,
  output logic                   rf_data_out,
  output logic                   modulation_select_out,
  output logic                   carrier_band_select_out,
  output logic      [4:0]        power_level_out,
  output logic      [FREQ_W-1:0] carrier_word_out,
  output logic      [FREQ_W-1:0] cal_ref_out,
  output logic      [BAND_W-1:0] vco_band_out,
  output logic                   baud_tick_out,
  output logic                   block_reset_out,
  output logic                   irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // derived counts
  localparam int CAL_STEP_CYC = (CAL_TIME_NS / (CLK_PERIOD_NS * BAND_W) > 0)
                              ? CAL_TIME_NS / (CLK_PERIOD_NS * BAND_W) : 1;
  localparam int LOCK_CYC     = (LOCK_TO_NS / CLK_PERIOD_NS > 0)
                              ? LOCK_TO_NS / CLK_PERIOD_NS : 1;
  localparam int TMR_W        = $clog2(LOCK_CYC + 1) + 1;

  initial begin
    if (FREQ_W < 2 || FREQ_W > 32) $error("FREQ_W must be 2..32");
    if (BAND_W < 1 || BAND_W > 8) $error("BAND_W must be 1..8");
    if (CAL_STEP_CYC >= LOCK_CYC) $error("lock timeout too short");
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for the analog pins
  logic [6:0] pin_meta_q;
  logic [6:0] pin_sync_q;
  logic       xco_prev_q;
  wire  [6:0] pin_raw = {rf_poweron_reset_in, pll_lock_in, crystal_osc_ok_in,
                         supply_low_in, dreg_ok_in, cap_ok_in, vco_above_ref_in};

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_meta_q <= 7'h00;
      pin_sync_q <= 7'h00;
      xco_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
      xco_prev_q <= pin_sync_q[4];
    end
  end

  wire por_s     = pin_sync_q[6];
  wire lock_s    = pin_sync_q[5];
  wire xco_s     = pin_sync_q[4];
  wire low_s     = pin_sync_q[3];
  wire dreg_s    = pin_sync_q[2];
  wire cap_s     = pin_sync_q[1];
  wire above_s   = pin_sync_q[0];
  wire xco_fall  = xco_prev_q & ~xco_s;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode; one wait cycle, answer on the second edge
  logic ack_q;
  wire  req      = avs_read_in | avs_write_in;
  wire  wr_fire  = avs_write_in & ack_q;
  wire  sel_baud = avs_address_in == ADDR_BAUD;
  wire  sel_ctrl = avs_address_in == ADDR_CTRL;
  wire  sel_stat = avs_address_in == ADDR_STATUS;
  wire  sel_rack = avs_address_in == ADDR_RSTACK;
  wire  sel_fa   = avs_address_in == ADDR_FREQA;
  wire  sel_fb   = avs_address_in == ADDR_FREQB;
  wire  wr_baud  = wr_fire & sel_baud;
  wire  wr_ctrl  = wr_fire & sel_ctrl;
  wire  wr_fa    = wr_fire & sel_fa;
  wire  wr_fb    = wr_fire & sel_fb;
  wire  soft_rst = wr_fire & sel_rack & avs_writedata_in[RST_BLOCK];
  wire  ack_w1   = wr_fire & sel_rack & avs_writedata_in[RST_ACK];

  assign avs_waitrequest_out = req & ~ack_q;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // block reset touches sequencing state and the baud divider; no buffer storage lives here
  wire blk_rst = soft_rst | por_s;
  assign block_reset_out = blk_rst;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [7:0]        baud_divider_q;
  logic              modulation_select_q;
  logic              carrier_band_select_q;
  logic [4:0]        power_level_q;
  logic              rf_irq_enable_q;
  logic              tx_lowvolt_enable_q;
  logic              precharge_enable_q;
  logic              per_frame_irq_select_q;
  logic [3:0]        frame_repeat_count_q;
  logic              direct_data_q;
  logic              direct_mode_q;
  logic [FREQ_W-1:0] freq_word_a_q;
  logic [FREQ_W-1:0] freq_word_b_q;
  wire  [4:0]        pwr_wr = avs_writedata_in[CTRL_PWR_LO +: 5];

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      baud_divider_q <= BAUD_RESET;
    end else if (blk_rst) begin
      baud_divider_q <= BAUD_RESET;
    end else if (wr_baud) begin
      baud_divider_q <= avs_writedata_in[7:0];
    end
  end

  // power field saturates at the top level
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {modulation_select_q, carrier_band_select_q, rf_irq_enable_q} <= 3'h0;
      {tx_lowvolt_enable_q, precharge_enable_q, per_frame_irq_select_q} <= 3'h0;
      {direct_data_q, direct_mode_q} <= 2'h0;
      power_level_q        <= 5'h00;
      frame_repeat_count_q <= 4'h0;
    end else if (wr_ctrl) begin
      modulation_select_q    <= avs_writedata_in[CTRL_MOD];
      carrier_band_select_q  <= avs_writedata_in[CTRL_BAND];
      power_level_q          <= (pwr_wr < PWR_LEVELS) ? pwr_wr : PWR_LEVELS - 5'd1;
      rf_irq_enable_q        <= avs_writedata_in[CTRL_IRQ_EN];
      tx_lowvolt_enable_q    <= avs_writedata_in[CTRL_LV_EN];
      precharge_enable_q     <= avs_writedata_in[CTRL_PC_EN];
      per_frame_irq_select_q <= avs_writedata_in[CTRL_PER_FRAME];
      frame_repeat_count_q   <= avs_writedata_in[CTRL_FRAMES_LO +: 4];
      direct_data_q          <= avs_writedata_in[CTRL_DDATA];
      direct_mode_q          <= avs_writedata_in[CTRL_DMODE];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      freq_word_a_q <= '0;
      freq_word_b_q <= '0;
    end else begin
      if (wr_fa) freq_word_a_q <= avs_writedata_in[FREQ_W-1:0];
      if (wr_fb) freq_word_b_q <= avs_writedata_in[FREQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  rtc_state_t        state_q;
  rtc_state_t        state_d;
  logic              send_q;
  logic [TMR_W-1:0]  tmr_q;
  logic [BAND_W-1:0] band_q;
  logic [BAND_W-1:0] probe_q;   // one-hot bit under trial
  logic              reg_ok_q;

  wire active     = state_q != RTC_IDLE;
  wire in_tx      = state_q == RTC_TX;
  wire start      = wr_ctrl & avs_writedata_in[CTRL_SEND] & ~active;
  wire sw_stop    = wr_ctrl & ~avs_writedata_in[CTRL_SEND] & active;
  wire lock_to    = state_q == RTC_LOCK && tmr_q == TMR_W'(LOCK_CYC - 1) && !lock_s;
  wire lock_lost  = in_tx & ~lock_s;
  wire abort      = active & (lock_to | lock_lost | xco_fall | ~xco_s);
  wire step_done  = tmr_q == TMR_W'(CAL_STEP_CYC - 1);
  wire cal_last   = probe_q[0];
  // one frame only when the repeat count is zero
  wire buf_end    = in_tx & frame_end_in & (frame_last_in | frame_repeat_count_q == 4'h0);
  wire frame_irq  = in_tx & frame_end_in & per_frame_irq_select_q & (frame_repeat_count_q != 4'h0);
  wire tx_stay    = in_tx & (state_d == RTC_TX) & ~blk_rst;   // still in tx after edge

  // next-state selection
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      RTC_IDLE:   if (start) state_d = RTC_REG_UP;
      RTC_REG_UP: if (dreg_s) state_d = precharge_enable_q ? RTC_PRECHG : RTC_CAL;
      RTC_PRECHG: if (cap_s) state_d = RTC_CAL;
      RTC_CAL:    if (step_done && cal_last) state_d = RTC_LOCK;
      RTC_LOCK:   if (lock_s) state_d = RTC_TX;
      RTC_TX:     if (buf_end) state_d = RTC_IDLE;
    endcase
    if (abort || sw_stop) state_d = RTC_IDLE;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= RTC_IDLE;
    end else if (blk_rst) begin
      state_q <= RTC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // send bit: set by start, cleared by end, abort, stop or block reset
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      send_q <= 1'b0;
    end else if (blk_rst || abort || buf_end || sw_stop) begin
      send_q <= 1'b0;
    end else if (start) begin
      send_q <= 1'b1;
    end
  end

  // shared timer for calibration steps and lock wait
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tmr_q <= '0;
    end else if (state_d != state_q || (state_q == RTC_CAL && step_done)) begin
      tmr_q <= '0;
    end else if (state_q == RTC_CAL || state_q == RTC_LOCK) begin
      tmr_q <= tmr_q + TMR_W'(1);
    end
  end

  // successive approximation, msb first, restarted on every vco start
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      band_q  <= '0;
      probe_q <= '0;
    end else if (state_q != RTC_CAL && state_d == RTC_CAL) begin
      probe_q <= {1'b1, {(BAND_W-1){1'b0}}};
      band_q  <= {1'b1, {(BAND_W-1){1'b0}}};
    end else if (state_q == RTC_CAL && step_done) begin
      probe_q <= probe_q >> 1;
      band_q  <= (above_s ? band_q & ~probe_q : band_q) | (probe_q >> 1);
    end
  end

  // regulator ok: set at 1.5 V crossing, cleared for each new start
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_ok_q <= 1'b0;
    end else if (blk_rst || start) begin
      reg_ok_q <= 1'b0;
    end else if (state_q == RTC_PRECHG && cap_s) begin
      reg_ok_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags; a set in the same cycle as an acknowledge wins
  logic tx_error_flag_q;
  logic tx_done_flag_q;
  logic tx_lowvolt_flag_q;
  wire  lv_event = tx_lowvolt_enable_q & in_tx & low_s;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_error_flag_q   <= 1'b0;
      tx_done_flag_q    <= 1'b0;
      tx_lowvolt_flag_q <= 1'b0;
    end else begin
      tx_error_flag_q   <= abort | (tx_error_flag_q & ~ack_w1);
      tx_done_flag_q    <= buf_end | frame_irq | (tx_done_flag_q & ~ack_w1);
      // ack only takes once the supply is back above threshold
      tx_lowvolt_flag_q <= lv_event | (tx_lowvolt_flag_q & ~(ack_w1 & ~low_s));
    end
  end

  assign irq_out = rf_irq_enable_q & (tx_error_flag_q | tx_done_flag_q);

  ////////////////////////////////////////////////////////////////////////////
  // baud divider: crystal ticks / 52, then / (divider + 1)
  logic [5:0] pre_q;
  logic [7:0] bcnt_q;
  logic       baud_q;
  wire        pre_wrap = xtal_tick_in & (pre_q == XTAL_PRE_LAST);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pre_q  <= 6'h00;
      bcnt_q <= 8'h00;
      baud_q <= 1'b0;
    end else if (!in_tx) begin
      pre_q  <= 6'h00;   // phase restarts with each transmission
      bcnt_q <= 8'h00;
      baud_q <= 1'b0;
    end else begin
      if (xtal_tick_in) pre_q <= pre_wrap ? 6'h00 : pre_q + 6'h01;
      if (pre_wrap) bcnt_q <= (bcnt_q == baud_divider_q) ? 8'h00 : bcnt_q + 8'h01;
      baud_q <= pre_wrap & (bcnt_q == baud_divider_q) & tx_stay;
    end
  end

  assign baud_tick_out = baud_q;

  ////////////////////////////////////////////////////////////////////////////
  // analog drive, registered
  wire [FREQ_W:0] word_sum = {1'b0, freq_word_a_q} + {1'b0, freq_word_b_q};
  wire            tx_bit   = direct_mode_q ? direct_data_q : buf_data_in;
  wire            pa_d     = send_q & tx_stay;
  logic           pa_q;
  logic           data_q;
  logic [FREQ_W-1:0] carrier_q;
  logic [FREQ_W-1:0] cal_ref_q;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pa_q      <= 1'b0;
      data_q    <= 1'b0;
      carrier_q <= '0;
      cal_ref_q <= '0;
    end else begin
      pa_q      <= pa_d;
      // ook keys the amplifier; fsk switches between the two words
      data_q    <= pa_d & tx_bit;
      carrier_q <= (modulation_select_q && !tx_bit) ? freq_word_a_q : freq_word_b_q;
      cal_ref_q <= modulation_select_q ? word_sum[FREQ_W:1] : freq_word_b_q;
    end
  end

  assign pa_en_out               = pa_q & (modulation_select_q | data_q);
  assign rf_data_out             = data_q;
  assign carrier_word_out        = carrier_q;
  assign cal_ref_out             = cal_ref_q;
  assign vco_band_out            = band_q;
  assign modulation_select_out   = modulation_select_q;
  assign carrier_band_select_out = carrier_band_select_q;
  assign power_level_out         = power_level_q;
  // transmitter held off while pre-charging
  assign areg_en_out             = active;
  assign precharge_on_out        = state_q == RTC_PRECHG;
  assign crystal_osc_en_out      = active;
  assign vco_en_out              = state_q == RTC_CAL || state_q == RTC_LOCK || in_tx;
  assign pll_en_out              = state_q == RTC_LOCK || in_tx;

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero
  wire ready_flag = in_tx & lock_s;
  wire [31:0] ctrl_rd = 32'({direct_mode_q, direct_data_q, frame_repeat_count_q,
                             per_frame_irq_select_q, precharge_enable_q,
                             tx_lowvolt_enable_q, rf_irq_enable_q, power_level_q,
                             carrier_band_select_q, modulation_select_q, send_q});
  wire [31:0] stat_rd = 32'({band_q, 3'h0, reg_ok_q, tx_done_flag_q,
                             tx_lowvolt_flag_q, tx_error_flag_q, ready_flag});
  wire [31:0] rd_mux  = sel_baud ? {24'h000000, baud_divider_q} :
                        sel_ctrl ? ctrl_rd :
                        sel_stat ? stat_rd :
                        sel_fa   ? 32'(freq_word_a_q) :
                        sel_fb   ? 32'(freq_word_b_q) : 32'h00000000;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (avs_read_in && !ack_q) begin
      avs_readdata_out <= rd_mux;
    end
  end

endmodule

`default_nettype wire

//--- rtc_properties.sv
// Purpose: port-level checks of the rf transmit sequencer
// Assumes: single clk_in domain, rst_b_in active low
// Notes:   bound to rtc_top, sees its ports only
`timescale 1ns/10ps
`default_nettype none
module rtc_properties (
  input wire logic clk_in, rst_b_in, pll_lock_in, crystal_osc_ok_in, dreg_ok_in, cap_ok_in,
  input wire logic areg_en_out, precharge_on_out, vco_en_out, pll_en_out, pa_en_out,
  input wire logic baud_tick_out, block_reset_out, irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////
  // sequencer order; synced inputs allow a few cycles of slack
  AST_PA_IN_TX: assert property (pa_en_out |-> pll_en_out && vco_en_out && areg_en_out)
    else $error("amplifier on outside transmit");
  AST_PC_AFTER_DREG: assert property ($rose(precharge_on_out) |-> dreg_ok_in && areg_en_out)
    else $error("precharge before digital regulator");
  AST_PC_EXCL: assert property (precharge_on_out |-> !vco_en_out && !pa_en_out)
    else $error("transmitter on during precharge");
  AST_PC_DONE: assert property ((precharge_on_out && cap_ok_in) [*3] |=> !precharge_on_out)
    else $error("precharge stuck after cap ok");
  AST_CAL_FIRST: assert property ($rose(vco_en_out) |-> !pll_en_out [*8])
    else $error("pll enabled before calibration");
  AST_CAL_TIME: assert property ($rose(vco_en_out) ##100 vco_en_out |-> pll_en_out)
    else $error("calibration too long");
  AST_LOCK_LOSS: assert property (pa_en_out ##1 !pll_lock_in [*6] |-> !pll_en_out)
    else $error("no abort on lock loss");
  AST_XTAL: assert property (!crystal_osc_ok_in [*5] |-> !vco_en_out && !areg_en_out)
    else $error("no abort on crystal fail");
  AST_BLK_RST: assert property (block_reset_out |=> !areg_en_out)
    else $error("block reset left stage on");
  AST_BAUD: assert property (baud_tick_out |-> pll_en_out ##1 !baud_tick_out)
    else $error("baud tick outside transmit");
  cover property ($rose(pa_en_out));
  cover property ($rose(irq_out));
  cover property ($fell(precharge_on_out));
endmodule
bind rtc_top rtc_properties i_chk (.*);
`default_nettype wire

//--- rtc_analog_model.sv
// Purpose: far side: regulators, pll lock, vco comparator, crystal
// Assumes: crystal ticks every clk_in cycle
// Notes:   ramps are short so runs stay brief
`timescale 1ns/10ps
`default_nettype none
module rtc_analog_model #(
  parameter logic [5:0] TARGET = 6'h2B
) (
  input  wire logic       clk_in,
  input  wire logic       areg_en_in,
  input  wire logic       precharge_on_in,
  input  wire logic       pll_en_in,
  input  wire logic [5:0] vco_band_in,
  input  wire logic       lock_ok_in,
  input  wire logic       xtal_fail_in,
  output logic            dreg_ok_out,
  output logic            cap_ok_out,
  output logic            pll_lock_out,
  output logic            vco_above_ref_out,
  output logic            crystal_osc_ok_out,
  output logic            xtal_tick_out
);
  logic [3:0] dreg_q = 4'h0;
  logic [3:0] cap_q  = 4'h0;
  logic [3:0] lock_q = 4'h0;
  ////////////////////////////////////////////////////////////
  // settle counters; lock drops at once when told to fail
  always @(posedge clk_in) begin
    dreg_q <= !areg_en_in ? 4'h0 : dreg_q + 4'(dreg_q != 4'hF);
    cap_q  <= !areg_en_in ? 4'h0 : cap_q + 4'(precharge_on_in && cap_q != 4'hF);
    lock_q <= !(pll_en_in && lock_ok_in) ? 4'h0 : lock_q + 4'(lock_q != 4'hF);
  end
  assign dreg_ok_out        = dreg_q > 4'h3;
  assign cap_ok_out         = cap_q > 4'h8;        // cap reached threshold
  assign pll_lock_out       = lock_q > 4'h9;
  assign vco_above_ref_out  = vco_band_in > TARGET; // trial band too high
  assign crystal_osc_ok_out = !xtal_fail_in;
  assign xtal_tick_out      = 1'b1;
endmodule
`default_nettype wire

//--- rf_transmit_control_tb.sv
// Purpose: register-driven tests of the rf transmit control block
// Assumes: short lock timeout of 400 cycles
// Notes:   outputs are sampled at the falling edge
`timescale 1ns/10ps
`default_nettype none
module rf_transmit_control_tb;
  import rtc_pkg::*;
  logic        clk_in = 1'b0, rst_b_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0, lok = 1'b1, xbad = 1'b0;
  logic        rf_poweron_reset_in = 1'b0, supply_low_in = 1'b0, buf_data_in = 1'b1;
  logic        frame_end_in = 1'b0, frame_last_in = 1'b0;
  logic [15:0] avs_address_in = 16'h0000;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rdat;
  logic        avs_waitrequest_out, pll_lock_in, crystal_osc_ok_in, dreg_ok_in, cap_ok_in, vco_above_ref_in;
  logic        xtal_tick_in, areg_en_out, precharge_on_out, crystal_osc_en_out, vco_en_out, pll_en_out, pa_en_out;
  logic        rf_data_out, modulation_select_out, carrier_band_select_out, baud_tick_out, block_reset_out, irq_out;
  logic [4:0]  power_level_out;
  logic [15:0] carrier_word_out, cal_ref_out;
  logic [5:0]  vco_band_out;
  int          err_count = 0, n_checks = 0, n;
  rtc_top #(.LOCK_TO_NS(20000)) i_dut (.*);
  rtc_analog_model i_rf (.clk_in, .areg_en_in(areg_en_out), .precharge_on_in(precharge_on_out),
    .pll_en_in(pll_en_out), .vco_band_in(vco_band_out), .lock_ok_in(lok), .xtal_fail_in(xbad),
    .dreg_ok_out(dreg_ok_in), .cap_ok_out(cap_ok_in), .pll_lock_out(pll_lock_in),
    .vco_above_ref_out(vco_above_ref_in), .crystal_osc_ok_out(crystal_osc_ok_in), .xtal_tick_out(xtal_tick_in));
  always #25 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= w;
    avs_read_in      <= !w;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_in);
      if (avs_waitrequest_out === 1'b0) break;
    end
    if (n == 50) begin
      chk(avs_waitrequest_out, 32'h0);
      results();
    end
    rdat = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
    @(negedge clk_in);
  endtask
  task automatic rdc(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat & m, e);
  endtask
  // polls a status bit; running out counts as a mismatch
  task automatic wst(input int b, input logic v);
    for (int i = 0; i < 400; i++) begin
      bus(1'b0, ADDR_STATUS, 32'h0);
      if (rdat[b] === v) return;
    end
    chk(32'(rdat[b]), 32'(v));
    results();
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rdc(ADDR_BAUD, 32'hFF, 32'h34);
    rdc(16'h1850, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, ADDR_FREQA, 32'h1000);
    bus(1'b1, ADDR_FREQB, 32'h2000);
    bus(1'b1, ADDR_BAUD, 32'h0);
    rdc(ADDR_BAUD, 32'hFF, 32'h0);
    $display("test regs done");
    bus(1'b1, ADDR_CTRL, 32'h5CF);                 // fsk, 434, power 25, precharge
    wst(STAT_READY, 1'b1);
    rdc(ADDR_STATUS, 32'h3F11, 32'h2B11);
    chk(power_level_out, 32'h14);
    chk(carrier_band_select_out, 32'h1);
    chk(modulation_select_out, 32'h1);
    chk(cal_ref_out, 32'h1800);
    for (n = 0; n < 200 && baud_tick_out !== 1'b1; n++) @(negedge clk_in);
    for (n = 1; n < 200; n++) begin
      @(negedge clk_in);
      if (baud_tick_out === 1'b1) break;
    end
    chk(32'(n), 32'h34);
    @(posedge clk_in);
    frame_end_in  <= 1'b1;
    frame_last_in <= 1'b1;
    @(posedge clk_in);
    frame_end_in  <= 1'b0;
    wst(STAT_DONE, 1'b1);
    rdc(ADDR_CTRL, 32'h1, 32'h0);
    chk(irq_out, 32'h1);
    bus(1'b1, ADDR_RSTACK, 32'h2);
    chk(irq_out, 32'h0);
    $display("test fsk done");
    bus(1'b1, ADDR_CTRL, 32'h101);                 // ook, 315, irq on
    wst(STAT_READY, 1'b1);
    chk(cal_ref_out, 32'h2000);
    chk(pa_en_out, 32'h1);
    @(posedge clk_in) lok <= 1'b0;
    wst(STAT_ERR, 1'b1);
    chk(pa_en_out, 32'h0);
    rdc(ADDR_CTRL, 32'h1, 32'h0);
    chk(irq_out, 32'h1);
    bus(1'b1, ADDR_RSTACK, 32'h2);
    rdc(ADDR_STATUS, 32'h2, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h1);
    wst(STAT_ERR, 1'b1);
    chk(irq_out, 32'h0);
    @(posedge clk_in) lok <= 1'b1;
    bus(1'b1, ADDR_RSTACK, 32'h2);
    $display("test lock done");
    bus(1'b1, ADDR_CTRL, 32'h1);
    wst(STAT_READY, 1'b1);
    @(posedge clk_in) xbad <= 1'b1;
    wst(STAT_ERR, 1'b1);
    @(posedge clk_in) xbad <= 1'b0;
    bus(1'b1, ADDR_RSTACK, 32'h2);
    bus(1'b1, ADDR_CTRL, 32'h201);
    wst(STAT_READY, 1'b1);
    @(posedge clk_in) supply_low_in <= 1'b1;
    wst(STAT_LV, 1'b1);
    bus(1'b1, ADDR_RSTACK, 32'h2);
    rdc(ADDR_STATUS, 32'h4, 32'h4);
    @(posedge clk_in) supply_low_in <= 1'b0;
    rdc(ADDR_STATUS, 32'h4, 32'h4);
    bus(1'b1, ADDR_RSTACK, 32'h2);
    rdc(ADDR_STATUS, 32'h4, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h0);
    rdc(ADDR_STATUS, 32'h3, 32'h0);
    chk(pll_en_out, 32'h0);
    $display("test abort done");
    bus(1'b1, ADDR_BAUD, 32'h12);
    bus(1'b1, ADDR_CTRL, 32'h1);
    wst(STAT_READY, 1'b1);
    bus(1'b1, ADDR_RSTACK, 32'h1);
    chk(vco_en_out, 32'h0);
    rdc(ADDR_BAUD, 32'hFF, 32'h34);
    bus(1'b1, ADDR_CTRL, 32'h1);
    @(posedge clk_in) rf_poweron_reset_in <= 1'b1;
    repeat (6) @(negedge clk_in);
    chk(areg_en_out, 32'h0);
    @(posedge clk_in) rf_poweron_reset_in <= 1'b0;
    $display("test reset done");
    results();
  end
endmodule
`default_nettype wire
